// >>> include/bcs_map.svh
// Named constants for the bank charge state sequencer
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define BCS_CLK_NS        40
`define BCS_SEC_NS        1000000000
`define BCS_EX_STEP_S     8'h02

// ----------------------------------------
// States and bank masks (bit 0 = bank A)
// ----------------------------------------
`define BCS_NUM_BANKS     4
`define BCS_FIRST_FLOAT   4'h4
`define BCS_LAST_STATE    4'h8
`define BCS_BANKS_ALL     4'hf
`define BCS_BANKS_ABC     4'h7
`define BCS_BANKS_AB      4'h3
`define BCS_BANKS_A       4'h1
`define BCS_BANKS_NONE    4'h0

// ----------------------------------------
// Alarm inputs and key sequence
// ----------------------------------------
`define BCS_ALARM_W       7
`define BCS_SEQ_IDLE      2'h0
`define BCS_SEQ_DIAG      2'h1
`define BCS_SEQ_INC1      2'h2
`define BCS_SEQ_INC2      2'h3

`endif

// >>> include/bcs_pkg.sv
// Types for the bank charge state sequencer
package bcs_pkg;

   // ----------------------------------------
   // Regulator states
   // ----------------------------------------
   typedef enum logic [3:0] {
      BCS_ST0 = 4'b0000,
      BCS_ST1 = 4'b0001,
      BCS_ST2 = 4'b0010,
      BCS_ST3 = 4'b0011,
      BCS_ST4 = 4'b0100,
      BCS_ST5 = 4'b0101,
      BCS_ST6 = 4'b0110,
      BCS_ST7 = 4'b0111,
      BCS_ST8 = 4'b1000
   } bcs_state_t;

   // ----------------------------------------
   // Exercise phases
   // ----------------------------------------
   typedef enum logic [2:0] {
      BCS_EX_CHARGE = 3'b000,
      BCS_EX_LOAD   = 3'b001,
      BCS_EX_EEPROM = 3'b010,
      BCS_EX_BANK   = 3'b011,
      BCS_EX_WALK   = 3'b100,
      BCS_EX_SERIAL = 3'b101
   } bcs_ex_t;

endpackage : bcs_pkg

// >>> hw/bcs_tick.sv
// Periodic one-cycle tick generator
`timescale 1ns/1ps
`default_nettype none

module bcs_tick #(
   parameter int unsigned PERIOD = 25000000
) (
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   // Tick
   output logic      o_tick
);

   logic [31:0] count;

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         count  <= 32'h0;
         o_tick <= 1'b0;
      end else if (count == 32'(PERIOD - 1)) begin
         count  <= 32'h0;
         o_tick <= 1'b1;
      end else begin
         count  <= count + 32'h1;
         o_tick <= 1'b0;
      end
   end

endmodule : bcs_tick

`default_nettype wire

// >>> hw/bcs_sequencer.sv
// Bank charge state sequencer with hardware exercise mode
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"

// What this block does
// - Nine regulator states, each selecting which charge banks are on.
// - Reset enters state 0 with every bank switched on.
// - Next state depends on present state and battery voltage.
// - Boost states 0-3 change only after the state change delay.
// - Float states 4-8 evaluate and change once per second.
// - From state 0 towards 4, banks switch off one per step, D first.
// - Alarm byte: input one at bit 0 to seven at bit 6, high active.
// - Exercise mode entered by diag key, increment twice, diag key.
// - Increment key in exercise mode pauses, a further press resumes.
// - Decrement key ends exercise mode, back to normal operation.
// - Exercise tests each bank alone in turn, A through D.
// - Exercise runs an EEPROM check and shows pass or fail.
// - After power-up display shows identity screen and battery voltage.
// - Exercise loops: charge, load, EEPROM, bank states, serial data.
module bcs_sequencer
   import bcs_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `BCS_SEC_NS / `BCS_CLK_NS,
   parameter int unsigned VOLT_W     = 16
) (
   // Clock and reset
   input  wire logic                    i_core_clk,
   input  wire logic                    i_rst,
   // Measurement and thresholds
   input  wire logic [VOLT_W-1:0]       i_batt_v,
   input  wire logic [VOLT_W-1:0]       i_boost_v,
   input  wire logic [VOLT_W-1:0]       i_reboost_v,
   input  wire logic [VOLT_W-1:0]       i_float_v,
   input  wire logic [7:0]              i_delay_s,
   // Keypad, one-cycle pulses
   input  wire logic                    i_key_diag,
   input  wire logic                    i_key_inc,
   input  wire logic                    i_decrement_key,
   // EEPROM check
   input  wire logic                    i_ee_done,
   input  wire logic                    i_ee_ok,
   // Alarm inputs
   input  wire logic [`BCS_ALARM_W-1:0] i_alarm,
   // Switch outputs
   output logic [`BCS_NUM_BANKS-1:0]    o_bank_en,
   output logic                         o_charge_en,
   output logic                         o_load_en,
   output logic [3:0]                   o_state,
   // Exercise status
   output logic                         o_exercise,
   output logic                         o_paused,
   output logic                         o_ee_start,
   output logic                         o_ee_valid,
   output logic                         o_ee_pass,
   output logic                         o_serial_send,
   // Display
   output logic                         o_disp_id,
   output logic [VOLT_W-1:0]            o_disp_volt,
   output logic [7:0]                   o_alarm_byte
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [3:0] bank_mask(input logic [3:0] st);
      case (st)
         4'h0:    bank_mask = `BCS_BANKS_ALL;
         4'h1:    bank_mask = `BCS_BANKS_ABC;
         4'h2:    bank_mask = `BCS_BANKS_AB;
         4'h3:    bank_mask = `BCS_BANKS_A;
         4'h4:    bank_mask = `BCS_BANKS_NONE;
         4'h5:    bank_mask = `BCS_BANKS_A;
         4'h6:    bank_mask = `BCS_BANKS_AB;
         4'h7:    bank_mask = `BCS_BANKS_ABC;
         4'h8:    bank_mask = `BCS_BANKS_ALL;
         default: bank_mask = `BCS_BANKS_NONE;
      endcase
   endfunction : bank_mask

   // Boost steps down while high, float trims one bank per second
   function automatic bcs_state_t reg_next(input bcs_state_t st, input logic [VOLT_W-1:0] v,
                                           input logic [VOLT_W-1:0] hi,
                                           input logic [VOLT_W-1:0] lo,
                                           input logic [VOLT_W-1:0] fl);
      reg_next = st;
      if (st < `BCS_FIRST_FLOAT) begin
         if (v >= hi)
            reg_next = bcs_state_t'(st + 4'h1);
         else if (v < lo && st != BCS_ST0)
            reg_next = bcs_state_t'(st - 4'h1);
      end else begin
         if (v < lo)
            reg_next = BCS_ST0;
         else if (v > fl && st > `BCS_FIRST_FLOAT)
            reg_next = bcs_state_t'(st - 4'h1);
         else if (v < fl && st < `BCS_LAST_STATE)
            reg_next = bcs_state_t'(st + 4'h1);
      end
   endfunction : reg_next

   // ----------------------------------------
   // One second tick
   // ----------------------------------------
   logic sec_tick;

   bcs_tick #(
      .PERIOD (SEC_CYCLES)
   ) u_sec (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .o_tick     (sec_tick)
   );

   // ----------------------------------------
   // Regulator
   // ----------------------------------------
   bcs_state_t reg_state;
   bcs_state_t next_reg_state;
   logic [7:0] delay_cnt;

   always_comb begin
      next_reg_state = reg_next(reg_state, i_batt_v, i_boost_v, i_reboost_v, i_float_v);
   end

   // Regulation holds still while the exercise owns the switches
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         reg_state <= BCS_ST0;
         delay_cnt <= 8'h0;
      end else if (o_exercise) begin
         delay_cnt <= 8'h0;
      end else if (sec_tick) begin
         if (reg_state < `BCS_FIRST_FLOAT) begin
            if (delay_cnt >= i_delay_s && next_reg_state != reg_state) begin
               reg_state <= next_reg_state;
               delay_cnt <= 8'h0;
            end else if (delay_cnt < i_delay_s) begin
               delay_cnt <= delay_cnt + 8'h1;
            end
         end else begin
            reg_state <= next_reg_state;
            delay_cnt <= 8'h0;
         end
      end
   end

   // ----------------------------------------
   // Exercise entry, pause and exit
   // ----------------------------------------
   logic [1:0] key_seq;
   logic       ex_enter;

   always_comb begin
      ex_enter = !o_exercise && i_key_diag && key_seq == `BCS_SEQ_INC2;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst || o_exercise) begin
         key_seq <= `BCS_SEQ_IDLE;
      end else if (i_key_diag) begin
         key_seq <= `BCS_SEQ_DIAG;
      end else if (i_key_inc && key_seq == `BCS_SEQ_DIAG) begin
         key_seq <= `BCS_SEQ_INC1;
      end else if (i_key_inc && key_seq == `BCS_SEQ_INC1) begin
         key_seq <= `BCS_SEQ_INC2;
      end else if (i_key_inc || i_decrement_key) begin
         key_seq <= `BCS_SEQ_IDLE;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_exercise <= 1'b0;
         o_paused   <= 1'b0;
      end else if (ex_enter) begin
         o_exercise <= 1'b1;
         o_paused   <= 1'b0;
      end else if (o_exercise && i_decrement_key) begin
         o_exercise <= 1'b0;
         o_paused   <= 1'b0;
      end else if (o_exercise && i_key_inc) begin
         o_paused   <= !o_paused;
      end
   end

   // ----------------------------------------
   // Exercise cycle
   // ----------------------------------------
   bcs_ex_t    ex_phase;
   logic [3:0] ex_sub;
   logic [7:0] ex_sec;
   logic       step_due;

   // The EEPROM phase waits for its result, not for the step time
   always_comb begin
      step_due = sec_tick && !o_paused && ex_sec == `BCS_EX_STEP_S - 8'h1;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst || ex_enter || !o_exercise) begin
         ex_phase   <= BCS_EX_CHARGE;
         ex_sub     <= 4'h0;
         ex_sec     <= 8'h0;
         o_ee_start <= 1'b0;
      end else begin
         o_ee_start <= 1'b0;
         if (ex_phase == BCS_EX_EEPROM) begin
            if (i_ee_done && !o_paused)
               ex_phase <= BCS_EX_BANK;
         end else if (sec_tick && !o_paused) begin
            ex_sec <= step_due ? 8'h0 : ex_sec + 8'h1;
         end
         if (step_due && ex_phase != BCS_EX_EEPROM) begin
            case (ex_phase)
               BCS_EX_CHARGE: ex_phase <= BCS_EX_LOAD;
               BCS_EX_LOAD: begin
                  ex_phase   <= BCS_EX_EEPROM;
                  o_ee_start <= 1'b1;
               end
               BCS_EX_BANK: begin
                  if (ex_sub == 4'(`BCS_NUM_BANKS - 1)) begin
                     ex_sub   <= 4'h0;
                     ex_phase <= BCS_EX_WALK;
                  end else begin
                     ex_sub <= ex_sub + 4'h1;
                  end
               end
               BCS_EX_WALK: begin
                  if (ex_sub == `BCS_LAST_STATE) begin
                     ex_sub   <= 4'h0;
                     ex_phase <= BCS_EX_SERIAL;
                  end else begin
                     ex_sub <= ex_sub + 4'h1;
                  end
               end
               BCS_EX_SERIAL: ex_phase <= BCS_EX_CHARGE;
               default:       ex_phase <= BCS_EX_CHARGE;
            endcase
         end
      end
   end

   // EEPROM verdict stays on display until the next check or the next exercise entry
   always_ff @(posedge i_core_clk) begin
      if (i_rst || ex_enter) begin
         o_ee_valid <= 1'b0;
         o_ee_pass  <= 1'b0;
      end else if (o_exercise && ex_phase == BCS_EX_EEPROM && i_ee_done) begin
         o_ee_valid <= 1'b1;
         o_ee_pass  <= i_ee_ok;
      end
   end

   // ----------------------------------------
   // Switch outputs
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_bank_en     <= `BCS_BANKS_ALL;
         o_state       <= 4'h0;
         o_charge_en   <= 1'b1;
         o_load_en     <= 1'b1;
         o_serial_send <= 1'b0;
      end else if (!o_exercise) begin
         o_bank_en     <= bank_mask(reg_state);
         o_state       <= reg_state;
         o_charge_en   <= 1'b1;
         o_load_en     <= 1'b1;
         o_serial_send <= 1'b0;
      end else begin
         o_charge_en   <= 1'b1;
         o_load_en     <= ex_phase != BCS_EX_CHARGE;
         o_serial_send <= ex_phase == BCS_EX_SERIAL;
         o_state       <= ex_phase == BCS_EX_WALK ? ex_sub : 4'h0;
         case (ex_phase)
            BCS_EX_BANK: o_bank_en <= 4'h1 << ex_sub[1:0];
            BCS_EX_WALK: o_bank_en <= bank_mask(ex_sub);
            default:     o_bank_en <= `BCS_BANKS_NONE;
         endcase
      end
   end

   // ----------------------------------------
   // Display
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_disp_id    <= 1'b1;
         o_disp_volt  <= '0;
         o_alarm_byte <= 8'h0;
      end else begin
         if (i_key_diag || i_key_inc || i_decrement_key)
            o_disp_id <= 1'b0;
         o_disp_volt  <= i_batt_v;
         o_alarm_byte <= {1'b0, i_alarm};
      end
   end

endmodule : bcs_sequencer

`default_nettype wire

// >>> bench/bcs_seq_checker.sv
// Concurrent checks on the sequencer top ports
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"

module bcs_seq_checker #(
   parameter int unsigned SEC_CYCLES = 10,
   parameter int unsigned VOLT_W     = 16
) (
   // Clock, reset and inputs
   input wire logic                    i_core_clk,
   input wire logic                    i_rst,
   input wire logic [VOLT_W-1:0]       i_batt_v,
   input wire logic                    i_key_diag,
   input wire logic                    i_key_inc,
   input wire logic                    i_decrement_key,
   input wire logic [`BCS_ALARM_W-1:0] i_alarm,
   // Watched outputs
   input wire logic [3:0]              o_bank_en,
   input wire logic [3:0]              o_state,
   input wire logic                    o_exercise,
   input wire logic                    o_paused,
   input wire logic                    o_ee_start,
   input wire logic [VOLT_W-1:0]       o_disp_volt,
   input wire logic [7:0]              o_alarm_byte
);
   // ----------------------------------------
   // Bank pattern per state
   // ----------------------------------------
   localparam logic [3:0] BANK_TBL [0:8] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0, 4'h1, 4'h3, 4'h7, 4'hf};

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   sequence s_entry;
      (!o_exercise && i_key_diag) ##1 i_key_inc ##1 i_key_inc ##1 (i_key_diag && !o_exercise);
   endsequence

   reset_entry_a: assert property (@(posedge i_core_clk) disable iff (1'b0)
      i_rst |=> o_state == 4'h0 && o_bank_en == 4'hf) else $error("reset state wrong");
   state_range_a: assert property (o_state <= 4'h8) else $error("state out of range");
   bank_decode_a: assert property (!o_exercise && !$past(o_exercise)
      |-> o_bank_en == BANK_TBL[o_state]) else $error("bank pattern wrong");
   // Exercise exit restores the saved state a cycle after o_exercise falls, so that change is not excluded
   hold_second_a: assert property (!o_exercise && !$past(o_exercise) && $changed(o_state)
      |=> ($stable(o_state) || o_exercise) [*8]) else $error("state changed too soon");
   alarm_map_a: assert property (!$past(i_rst)
      |-> o_alarm_byte == {1'b0, $past(i_alarm)}) else $error("alarm byte wrong");
   volt_shown_a: assert property (!$past(i_rst)
      |-> o_disp_volt == $past(i_batt_v)) else $error("voltage shown wrong");
   exercise_entry_a: assert property (s_entry |=> o_exercise) else $error("no exercise entry");
   pause_toggle_a: assert property (o_exercise && i_key_inc && !i_decrement_key
      |=> o_paused != $past(o_paused)) else $error("pause not toggled");
   pause_hold_a: assert property (o_exercise && o_paused && $past(o_paused)
      && !i_key_inc && !i_decrement_key
      |=> $stable(o_bank_en)) else $error("banks moved while paused");
   decrement_exit_a: assert property (o_exercise && i_decrement_key
      |=> !o_exercise) else $error("exercise not ended");
   ee_launch_a: assert property (o_ee_start |-> o_exercise ##1 !o_ee_start)
      else $error("eeprom start wrong");

   cover property (s_entry);
   cover property (o_exercise && o_paused);
   cover property (!o_exercise && o_state == 4'h8);
endmodule : bcs_seq_checker
`default_nettype wire

// >>> bench/bcs_bank_model.sv
// Bank switches, battery sense and eeprom responder
`timescale 1ns/1ps
`default_nettype none

module bcs_bank_model #(
   parameter int unsigned VOLT_W = 16,
   parameter int unsigned EE_LAT = 4
) (
   // Clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   // Switch side and scene
   input  wire logic [3:0]        i_bank_en,
   input  wire logic [VOLT_W-1:0] i_level,
   input  wire logic              i_ee_start,
   input  wire logic              i_ok_cfg,
   // Answers
   output logic [VOLT_W-1:0]      o_batt_v,
   output logic                   o_ee_done,
   output logic                   o_ee_ok
);
   int cnt;

   // Each bank on lifts the sensed voltage a little
   always_ff @(posedge i_core_clk) begin
      o_batt_v <= i_level + VOLT_W'($countones(i_bank_en));
   end

   // Result line shows the inverse outside the done pulse
   always_ff @(posedge i_core_clk) begin
      cnt       <= i_rst ? 0 : i_ee_start ? EE_LAT : (cnt > 0) ? cnt - 1 : 0;
      o_ee_done <= !i_rst && cnt == 1;
      o_ee_ok   <= (cnt == 1) ? i_ok_cfg : !i_ok_cfg;
   end
endmodule : bcs_bank_model
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking testbench for the bank charge state sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam int unsigned SEC = 10;
   localparam logic [3:0] BANKS [0:8] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
   logic        i_core_clk = 1'b0;
   logic        i_rst      = 1'b1;
   logic [15:0] level      = 16'h0310;
   logic [6:0]  alarm      = 7'h00;
   logic        diag       = 1'b0;
   logic        inc        = 1'b0;
   logic        decr       = 1'b0;
   logic        ok_cfg     = 1'b1;
   logic [15:0] boost_v    = 16'h0300;
   logic [15:0] reboost_v  = 16'h0200;
   logic [15:0] float_v    = 16'h0280;
   logic [7:0]  delay_s    = 8'h02;
   logic [15:0] batt_v, disp_volt;
   logic [3:0]  bank_en, state;
   logic [7:0]  alarm_byte;
   logic        charge_en, load_en, exer, paused, ee_start, ee_valid, ee_pass, disp_id;
   logic        ee_done, ee_ok, serial;
   int          n_fail      = 0;
   int          checks_done = 0;
   int          n;

   always #20 i_core_clk = ~i_core_clk;

   bcs_sequencer #(.SEC_CYCLES(SEC), .VOLT_W(16)) uut (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_batt_v(batt_v), .i_boost_v(boost_v),
      .i_reboost_v(reboost_v), .i_float_v(float_v), .i_delay_s(delay_s), .i_key_diag(diag),
      .i_key_inc(inc), .i_decrement_key(decr), .i_ee_done(ee_done), .i_ee_ok(ee_ok),
      .i_alarm(alarm), .o_bank_en(bank_en), .o_charge_en(charge_en), .o_load_en(load_en),
      .o_state(state), .o_exercise(exer), .o_paused(paused), .o_ee_start(ee_start),
      .o_ee_valid(ee_valid), .o_ee_pass(ee_pass), .o_serial_send(serial), .o_disp_id(disp_id),
      .o_disp_volt(disp_volt), .o_alarm_byte(alarm_byte));

   bcs_bank_model #(.VOLT_W(16), .EE_LAT(4)) u_model (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_bank_en(bank_en), .i_level(level),
      .i_ee_start(ee_start), .i_ok_cfg(ok_cfg), .o_batt_v(batt_v), .o_ee_done(ee_done),
      .o_ee_ok(ee_ok));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task wrap_up;
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [15:0] pick(input int sel);
      return sel == 0 ? {12'h0, state} : sel == 1 ? {12'h0, bank_en} :
             sel == 2 ? {15'h0, ee_valid} : sel == 3 ? {15'h0, ee_pass} : {15'h0, serial};
   endfunction : pick

   // Bounded wait, n holds the cycles taken
   task wait_for(input int sel, input logic [15:0] v, input int lim);
      n = 0;
      while (pick(sel) !== v) begin
         @(negedge i_core_clk);
         n++;
         if (n > lim) begin
            chk(pick(sel), v);
            wrap_up();
         end
      end
   endtask : wait_for

   task keys(input logic [2:0] k);
      @(negedge i_core_clk);
      {diag, inc, decr} = k;
   endtask : keys

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(negedge i_core_clk);
      i_rst = 1'b0;
      @(negedge i_core_clk);
      chk({12'h0, state}, 16'h0000);
      chk({12'h0, bank_en}, 16'h000f);
      chk({14'h0, charge_en, load_en}, 16'h0003);
      chk({15'h0, disp_id}, 16'h0001);
      alarm = 7'h55;
      repeat (2) @(negedge i_core_clk);
      chk({8'h0, alarm_byte}, 16'h0055);
      chk(disp_volt, 16'h0314);
      // Boost steps wait out the two second delay
      for (int s = 1; s <= 4; s++) begin
         wait_for(0, 16'(s), (delay_s + 1) * SEC + 2);
         chk({12'h0, bank_en}, {12'h0, BANKS[s]});
         if (s > 1) chk(16'(n), 16'((delay_s + 1) * SEC));
      end
      level = 16'h0250;
      for (int s = 5; s <= 8; s++) begin
         wait_for(0, 16'(s), SEC + 2);
         chk({12'h0, bank_en}, {12'h0, BANKS[s]});
         if (s > 5) chk(16'(n), 16'(SEC));
      end
      level = 16'h0100;
      wait_for(0, 16'h0000, SEC + 2);
      chk({12'h0, bank_en}, 16'h000f);
      // A broken key sequence must not enter exercise
      keys(3'b100);
      keys(3'b010);
      keys(3'b100);
      keys(3'b000);
      repeat (2) @(negedge i_core_clk);
      chk({15'h0, exer}, 16'h0000);
      chk({15'h0, disp_id}, 16'h0000);
      keys(3'b100);
      keys(3'b010);
      keys(3'b010);
      keys(3'b100);
      keys(3'b000);
      chk({15'h0, exer}, 16'h0001);
      @(negedge i_core_clk);
      chk({10'h0, charge_en, load_en, bank_en}, 16'h0020);
      wait_for(2, 16'h0001, 6 * SEC);
      chk({15'h0, ee_pass}, 16'h0001);
      wait_for(1, 16'h0001, 4 * SEC);
      wait_for(1, 16'h0002, 3 * SEC);
      keys(3'b010);
      keys(3'b000);
      chk({15'h0, paused}, 16'h0001);
      repeat (3 * SEC) @(negedge i_core_clk);
      chk({12'h0, bank_en}, 16'h0002);
      keys(3'b010);
      keys(3'b000);
      chk({15'h0, paused}, 16'h0000);
      wait_for(1, 16'h0004, 3 * SEC);
      wait_for(1, 16'h0008, 3 * SEC);
      wait_for(0, 16'h0008, 20 * SEC);
      wait_for(4, 16'h0001, 4 * SEC);
      chk({12'h0, bank_en}, 16'h0000);
      ok_cfg = 1'b0;
      wait_for(3, 16'h0000, 10 * SEC);
      keys(3'b001);
      keys(3'b000);
      chk({15'h0, exer}, 16'h0000);
      repeat (2) @(negedge i_core_clk);
      chk({12'h0, bank_en}, 16'h000f);
      wrap_up();
   end
endmodule : tb_top

bind bcs_sequencer bcs_seq_checker #(.SEC_CYCLES(SEC_CYCLES), .VOLT_W(VOLT_W)) u_chk (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_batt_v(i_batt_v), .i_key_diag(i_key_diag),
   .i_key_inc(i_key_inc), .i_decrement_key(i_decrement_key), .i_alarm(i_alarm),
   .o_bank_en(o_bank_en), .o_state(o_state), .o_exercise(o_exercise), .o_paused(o_paused),
   .o_ee_start(o_ee_start), .o_disp_volt(o_disp_volt), .o_alarm_byte(o_alarm_byte));
`default_nettype wire
